// ===== pkg/pad_cfg_pkg.sv
/*
 Package for the pad configuration and soft reset register bank:
 register addresses, field positions, reset values and carrier types.
 Assumes a 16-bit address, 16-bit data control port decoded upstream.
*/
package pad_cfg_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    localparam logic [15:0] ADDR_MASTER_DATA_OUT_PAD = 16'hF7A0;
    localparam logic [15:0] ADDR_MULTIPURPOSE_SIX_PAD = 16'hF7A1;
    localparam logic [15:0] ADDR_MULTIPURPOSE_SEVEN_PAD = 16'hF7A2;
    localparam logic [15:0] ADDR_CLOCK_OUTPUT_PAD = 16'hF7A3;
    localparam logic [15:0] ADDR_SOFTWARE_RESET_CONTROL = 16'hF890;
    localparam logic [15:0] ADDR_PLL_FIRST = 16'hF000;
    localparam logic [15:0] ADDR_PLL_LAST = 16'hF006;

    localparam logic [15:0] RST_MASTER_DATA_OUT_PAD = 16'h0018;
    localparam logic [15:0] RST_MULTIPURPOSE_SIX_PAD = 16'h0018;
    localparam logic [15:0] RST_MULTIPURPOSE_SEVEN_PAD = 16'h0018;
    localparam logic [15:0] RST_CLOCK_OUTPUT_PAD = 16'h0008;
    localparam logic [15:0] RST_SOFTWARE_RESET_CONTROL = 16'h0001;

    localparam int PAD_PULL_BIT = 4;
    localparam int PAD_SLEW_MSB = 3;
    localparam int PAD_SLEW_LSB = 2;
    localparam int PAD_DRIVE_MSB = 1;
    localparam int PAD_DRIVE_LSB = 0;
    localparam int PAD_USED_MSB = 4;
    localparam int SOFT_RESET_N_BIT = 0;

    localparam int PAD_COUNT = 4;
    localparam logic [1:0] PAD_IDX_MASTER = 2'h0;
    localparam logic [1:0] PAD_IDX_SIX = 2'h1;
    localparam logic [1:0] PAD_IDX_SEVEN = 2'h2;
    localparam logic [1:0] PAD_IDX_CLOCK = 2'h3;

    typedef struct packed {
        logic       pull_en;
        logic [1:0] slew_sel;
        logic [1:0] drive_sel;
    } pad_ctrl_t;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
endpackage

// ===== rtl/pad_config_soft_reset_regs.sv
/*
 Pad configuration and soft reset register bank for four pads.
 Holds the four pad stores, the soft reset control and the read path.
 Pad fields leave as static levels; PLL writes are only flagged, since
 the PLL and panic-manager registers live outside and are never cleared.
 Assumes the I2C/SPI slave port delivers one-cycle write and read
 strobes on clk, and owns the control-port mode itself; this bank only
 reports soft reset, which that port must ignore.
*/
`timescale 1ns/100ps
`default_nettype none
module pad_config_soft_reset_regs
    import pad_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire reg_req_t    req,
    output logic [15:0]      rdata_reg,
    output logic             rvalid_reg,
    output logic             soft_reset_active_reg,
    output logic             pll_write_reg,
    output logic             multipurpose_pin_one_pull_en,
    output logic [1:0]       multipurpose_pin_one_slew_sel,
    output logic [1:0]       multipurpose_pin_one_drive_sel,
    output logic             multipurpose_six_pulldown_en,
    output logic [1:0]       multipurpose_six_slew_sel,
    output logic [1:0]       multipurpose_six_drive_sel,
    output logic             multipurpose_seven_pulldown_en,
    output logic [1:0]       multipurpose_seven_slew_sel,
    output logic [1:0]       multipurpose_seven_drive_sel,
    output logic             clock_output_pulldown_en,
    output logic [1:0]       clock_output_slew_sel,
    output logic [1:0]       clock_output_drive_sel
);
    localparam logic [15:0] PAD_ADDR [PAD_COUNT] = '{
        ADDR_MASTER_DATA_OUT_PAD, ADDR_MULTIPURPOSE_SIX_PAD,
        ADDR_MULTIPURPOSE_SEVEN_PAD, ADDR_CLOCK_OUTPUT_PAD};
    localparam logic [15:0] PAD_RST [PAD_COUNT] = '{
        RST_MASTER_DATA_OUT_PAD, RST_MULTIPURPOSE_SIX_PAD,
        RST_MULTIPURPOSE_SEVEN_PAD, RST_CLOCK_OUTPUT_PAD};

    logic                 soft_reset_n_reg;
    logic                 soft_reset_n_next;
    logic                 soft_wr;
    logic                 bank_clear;
    logic [PAD_COUNT-1:0] pad_wr;
    logic                 pll_write_next;
    logic                 rvalid_next;
    logic [15:0]          rdata_next;
    pad_ctrl_t            pad_reg [PAD_COUNT];

    function automatic logic is_pll_addr(
        input logic [15:0] a
    );
        return (a >= ADDR_PLL_FIRST) && (a <= ADDR_PLL_LAST);
    endfunction

    // Strobe for a write to one register address
    function automatic logic write_hit(
        input reg_req_t    r,
        input logic [15:0] a
    );
        return r.wr_en && (r.addr == a);
    endfunction

    // Reserved bits are never stored, so they read as zero
    function automatic logic [15:0] pad_word(input pad_ctrl_t p);
        return {11'h000, p};
    endfunction

    // Same for the soft reset word
    function automatic logic [15:0] soft_word(input logic n);
        return {15'h0000, n};
    endfunction

    // One strobe per pad store
    always_comb begin
        for (int i = 0; i < PAD_COUNT; i++) begin
            pad_wr[i] = write_hit(req, PAD_ADDR[i]);
        end
    end

    assign soft_wr = write_hit(req, ADDR_SOFTWARE_RESET_CONTROL);

    // Soft reset clears the pads like srst does, but never itself;
    // port mode lives outside this bank, so soft reset cannot touch it
    assign bank_clear = srst | ~soft_reset_n_reg;

    genvar g;
    generate
        for (g = 0; g < PAD_COUNT; g++) begin : pads
            pad_field_store #(
                .RESET_VALUE (PAD_RST[g])
            ) u_store (
                .clk      (clk),
                .clear    (bank_clear),
                .wr_en    (pad_wr[g]),
                .wdata    (req.wdata),
                .ctrl_reg (pad_reg[g])
            );
        end
    endgenerate

    always_comb begin
        soft_reset_n_next = soft_reset_n_reg;
        if (soft_wr) begin
            soft_reset_n_next = req.wdata[SOFT_RESET_N_BIT];
        end
    end

    // Only srst restores the default; the control itself stays writable
    // so software can leave soft reset
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reset_n_reg <= RST_SOFTWARE_RESET_CONTROL[SOFT_RESET_N_BIT];
        end else begin
            soft_reset_n_reg <= soft_reset_n_next;
        end
    end

    // Report only; the port keeps its slave mode through soft reset
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reset_active_reg <= 1'b0;
        end else begin
            soft_reset_active_reg <= ~soft_reset_n_reg;
        end
    end

    // PLL writes pass on during soft reset; that bank sits outside
    assign pll_write_next = req.wr_en && is_pll_addr(req.addr);

    always_ff @(posedge clk) begin
        if (srst) begin
            pll_write_reg <= 1'b0;
        end else begin
            pll_write_reg <= pll_write_next;
        end
    end

    // Read path keeps answering during soft reset
    always_comb begin
        rvalid_next = req.rd_en;
        rdata_next  = 16'h0000;
        if (req.rd_en) begin
            case (req.addr)
                ADDR_MASTER_DATA_OUT_PAD: begin
                    rdata_next = pad_word(pad_reg[PAD_IDX_MASTER]);
                end
                ADDR_MULTIPURPOSE_SIX_PAD: begin
                    rdata_next = pad_word(pad_reg[PAD_IDX_SIX]);
                end
                ADDR_MULTIPURPOSE_SEVEN_PAD: begin
                    rdata_next = pad_word(pad_reg[PAD_IDX_SEVEN]);
                end
                ADDR_CLOCK_OUTPUT_PAD: begin
                    rdata_next = pad_word(pad_reg[PAD_IDX_CLOCK]);
                end
                ADDR_SOFTWARE_RESET_CONTROL: begin
                    rdata_next = soft_word(soft_reset_n_reg);
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    // Answer stands one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rvalid_next;
        end
    end

    // Zero between reads keeps the return bus quiet
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Master data-out pad, straight from its store flops
    assign multipurpose_pin_one_pull_en   = pad_reg[PAD_IDX_MASTER].pull_en;
    assign multipurpose_pin_one_slew_sel  = pad_reg[PAD_IDX_MASTER].slew_sel;
    assign multipurpose_pin_one_drive_sel = pad_reg[PAD_IDX_MASTER].drive_sel;

    // Pin six pad
    assign multipurpose_six_pulldown_en = pad_reg[PAD_IDX_SIX].pull_en;
    assign multipurpose_six_slew_sel      = pad_reg[PAD_IDX_SIX].slew_sel;
    assign multipurpose_six_drive_sel     = pad_reg[PAD_IDX_SIX].drive_sel;

    // Pin seven pad
    assign multipurpose_seven_pulldown_en = pad_reg[PAD_IDX_SEVEN].pull_en;
    assign multipurpose_seven_slew_sel    = pad_reg[PAD_IDX_SEVEN].slew_sel;
    assign multipurpose_seven_drive_sel   = pad_reg[PAD_IDX_SEVEN].drive_sel;

    // Clock-output pad
    assign clock_output_pulldown_en       = pad_reg[PAD_IDX_CLOCK].pull_en;
    assign clock_output_slew_sel          = pad_reg[PAD_IDX_CLOCK].slew_sel;
    assign clock_output_drive_sel         = pad_reg[PAD_IDX_CLOCK].drive_sel;
endmodule
`default_nettype wire

// ===== rtl/pad_field_store.sv
/*
 One pad configuration register: holds the pull, slew and drive fields.
 Assumes the caller qualifies writes and supplies the reset value.
*/
`timescale 1ns/100ps
`default_nettype none
module pad_field_store
    import pad_cfg_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0018
) (
    input  wire logic        clk,
    input  wire logic        clear,
    input  wire logic        wr_en,
    input  wire logic [15:0] wdata,
    output var  pad_ctrl_t   ctrl_reg
);
    // Reserved bits hold nothing, so they read as zero
    always_ff @(posedge clk) begin
        if (clear) begin
            ctrl_reg <= pad_ctrl_t'(RESET_VALUE[PAD_USED_MSB:0]);
        end else if (wr_en) begin
            ctrl_reg <= pad_ctrl_t'(wdata[PAD_USED_MSB:0]);
        end
    end
endmodule
`default_nettype wire

// ===== verification/host_port_model.sv
/*
 Host on the control port: one strobe per cycle pair.
 Assumes the read answer lands on the edge that takes the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module host_port_model
    import pad_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] rdata_reg,
    input  wire logic        rvalid_reg,
    output var reg_req_t     req
);
    initial req = '0;
    // Idle cycle between strobes, so no signal moves twice in a step
    task automatic xfer(input logic w, input logic [15:0] a, d,
                        output logic [15:0] q, output logic v);
        @(posedge clk);
        #1 req = '{w, !w, a, d};
        @(posedge clk);
        #1 req = '0;
        q = rdata_reg;
        v = rvalid_reg;
    endtask
endmodule
`default_nettype wire

// ===== verification/pad_cfg_chk.sv
/*
 Checker for the pad and soft reset bank ports.
 Assumes a bind to the bank top; one clock, srst synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module pad_cfg_chk
    import pad_cfg_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire reg_req_t    req,
    input wire logic [15:0] rdata_reg,
    input wire logic        rvalid_reg,
    input wire logic        soft_reset_active_reg,
    input wire logic        pll_write_reg,
    input wire logic        multipurpose_six_pulldown_en,
    input wire logic [1:0]  multipurpose_six_slew_sel,
    input wire logic [1:0]  multipurpose_six_drive_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic [4:0] six = {multipurpose_six_pulldown_en,
        multipurpose_six_slew_sel, multipurpose_six_drive_sel};
    sequence soft_enter_s;
        req.wr_en && req.addr == 16'hF890 && !req.wdata[0];
    endsequence
    sequence soft_held_s;
        ##[1:2] soft_reset_active_reg;
    endsequence
    rd_answer_a: assert property (req.rd_en |=> rvalid_reg)
        else $error("read not answered");
    pad_rsvd_a: assert property (req.rd_en && req.addr[15:2] == 14'h3DE8
        |=> rdata_reg[15:5] == 11'h000) else $error("pad reserved set");
    soft_rsvd_a: assert property (req.rd_en && req.addr == 16'hF890
        |=> rdata_reg[15:1] == 15'h0000) else $error("soft reserved set");
    six_write_a: assert property (req.wr_en && req.addr == 16'hF7A1
        && !soft_reset_active_reg && !$past(req.wr_en)
        |=> six == $past(req.wdata[4:0])) else $error("six pad not written");
    soft_hold_a: assert property (soft_reset_active_reg
        |-> six == 5'h18) else $error("six pad not at default");
    soft_enter_a: assert property (soft_enter_s |-> soft_held_s)
        else $error("soft reset not reported");
    pll_flag_a: assert property (req.wr_en && req.addr inside
        {[16'hF000:16'hF006]} |=> pll_write_reg) else $error("pll write lost");
    pad_stable_a: assert property (!req.wr_en && !$past(req.wr_en)
        |=> $stable(six)) else $error("six pad moved");
endmodule
bind pad_config_soft_reset_regs pad_cfg_chk chk (.*);
`default_nettype wire

// ===== verification/tb_top.sv
/*
 Register-level bench of the pad and soft reset bank.
 Assumes host_port_model and the bound checker are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pad_cfg_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    reg_req_t req;
    logic [15:0] rdata_reg, e, q;
    logic rvalid_reg, soft_reset_active_reg, pll_write_reg, v;
    wire [4:0] pad [4];
    int err_count = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    host_port_model host (.clk, .rdata_reg, .rvalid_reg, .req);
    pad_config_soft_reset_regs dut (.clk, .srst, .req, .rdata_reg,
        .rvalid_reg, .soft_reset_active_reg, .pll_write_reg,
        .multipurpose_pin_one_pull_en(pad[0][4]),
        .multipurpose_pin_one_slew_sel(pad[0][3:2]),
        .multipurpose_pin_one_drive_sel(pad[0][1:0]),
        .multipurpose_six_pulldown_en(pad[1][4]),
        .multipurpose_six_slew_sel(pad[1][3:2]),
        .multipurpose_six_drive_sel(pad[1][1:0]),
        .multipurpose_seven_pulldown_en(pad[2][4]),
        .multipurpose_seven_slew_sel(pad[2][3:2]),
        .multipurpose_seven_drive_sel(pad[2][1:0]),
        .clock_output_pulldown_en(pad[3][4]),
        .clock_output_slew_sel(pad[3][3:2]),
        .clock_output_drive_sel(pad[3][1:0]));
    task automatic chk(input string n, input logic [15:0] s, x);
        checks_done++;
        if (s !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
            err_count++;
        end
    endtask
    task automatic wr(input logic [15:0] a, d);
        host.xfer(1'b1, a, d, q, v);
    endtask
    task automatic rdc(input logic [15:0] a, x);
        host.xfer(1'b0, a, 16'h0000, q, v);
        chk("rvalid", {15'h0000, v}, 16'h0001);
        chk("rdata", q, x);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        err_count++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            e = (i == 3) ? 16'h0008 : 16'h0018;
            rdc(16'hF7A0 + 16'(i), e);
            chk("pad", {11'h000, pad[i]}, e);
        end
        rdc(16'hF890, 16'h0001);
        $display("test reset done");
        // Every slew and drive code, reserved bits set on purpose
        for (int k = 0; k < 16; k++) begin
            e = 16'(k) | {11'h000, k[0], 4'h0};
            wr(16'hF7A3, e | 16'hFFE0);
            chk("clock pad", {11'h000, pad[3]}, e);
            rdc(16'hF7A3, e);
        end
        rdc(16'hF7A4, 16'h0000);
        $display("test fields done");
        // Distinct word per pad, so crossed address decodes show up
        for (int i = 0; i < 4; i++) begin
            e = 16'h0011 ^ 16'(i * 7);
            wr(16'hF7A0 + 16'(i), e);
        end
        for (int i = 0; i < 4; i++) begin
            e = 16'h0011 ^ 16'(i * 7);
            chk("pad word", {11'h000, pad[i]}, e);
            rdc(16'hF7A0 + 16'(i), e);
        end
        $display("test decode done");
        wr(16'hF7A1, 16'h0003);
        wr(16'hF890, 16'h0000);
        wr(16'hF7A1, 16'h0007);
        wr(16'hF003, 16'h1234);
        chk("pll", {15'h0000, pll_write_reg}, 16'h0001);
        chk("soft", {15'h0000, soft_reset_active_reg}, 16'h0001);
        rdc(16'hF7A1, 16'h0018);
        rdc(16'hF7A3, 16'h0008);
        rdc(16'hF890, 16'h0000);
        wr(16'hF890, 16'h0001);
        wr(16'hF7A1, 16'h000E);
        chk("six pad", {11'h000, pad[1]}, 16'h000E);
        chk("soft off", {15'h0000, soft_reset_active_reg}, 16'h0000);
        $display("test soft reset done");
        wr(16'hF890, 16'h0000);
        @(posedge clk);
        #1 srst = 1'b1;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        rdc(16'hF890, 16'h0001);
        rdc(16'hF7A1, 16'h0018);
        chk("soft hard", {15'h0000, soft_reset_active_reg}, 16'h0000);
        $display("test hard reset done");
        final_report;
    end
endmodule
`default_nettype wire
